// file: include/scsr_regs.svh
// Purpose: register offsets, field positions, codes and reset values
// Assumes: one 16-bit register port, six address bits
// Notes:   included by bare name from the design files
//
// Overview of operation
// R01 - B select codes five-nine map to inputs
// R02 - A select field uses same mapping
// R03 - code 1011 returns AAAA and 5555 words
// R04 - status word is read only to host
// R05 - either enable appends status after last word
// R06 - status also follows self-test result words
// R07 - status bits 15:12 hold previous A index
// R08 - status bits 11:8 hold previous B index
// R09 - status bits 7:0 hold result checksum
// R10 - codes 0000-0100 choose inputs zero-four
// R11 - final flag wraps sequence, else advance
// R12 - reset reloads eight layers, clears rest
// R13 - no enable means no status word appended
// R14 - host must not write reserved select codes
`ifndef SCSR_REGS_SVH
`define SCSR_REGS_SVH

// register map
`define SCSR_CFG_ADDR      6'h02
`define SCSR_STAT_ADDR     6'h1E
`define SCSR_STACK_BASE    6'h20
`define SCSR_LAYERS        32
`define SCSR_LAST_LAYER    5'h1F

// configuration fields
`define SCSR_CFG_STATUS_EN 0
`define SCSR_CFG_CKSUM_EN  1
`define SCSR_CFG_PRESET    2

// layer fields
`define SCSR_FINAL_BIT     8
`define SCSR_BSEL_MSB      7
`define SCSR_BSEL_LSB      4
`define SCSR_ASEL_MSB      3
`define SCSR_ASEL_LSB      0
`define SCSR_INIT_LAYERS   8

// select codes
`define SCSR_CODE_SUPPLY   4'h8
`define SCSR_CODE_REGMON   4'h9
`define SCSR_CODE_RSV0     4'hA
`define SCSR_CODE_SELFTEST 4'hB
`define SCSR_CODE_RSV1     4'hC

// self-test result patterns and checksum
`define SCSR_TEST_A        16'hAAAA
`define SCSR_TEST_B        16'h5555
`define SCSR_CRC_POLY      8'h07
`define SCSR_CRC_INIT      8'h00

`endif

// file: include/scsr_pkg.sv
// Purpose: shared types of the sequencer readout block
// Assumes: nothing
// Notes:   constants live in scsr_regs.svh
package scsr_pkg;

  // readout sequencing states
  typedef enum logic [1:0] {
    S_IDLE,
    S_CONV,
    S_WORDB,
    S_STATUS
  } scsr_state_e;

endpackage

// file: hdl/scsr_sel_decode.sv
// Purpose: decode one 4-bit converter input select code
// Assumes: code is held stable by a register
// Notes:   codes 1101-1111 are flagged like the reserved ones
`timescale 1ns/1ps
`default_nettype none
`include "scsr_regs.svh"

module scsr_sel_decode (
  input  wire logic [3:0] code,
  output logic      [7:0] analogSel,
  output logic            supplySel,
  output logic            regulatorSel,
  output logic            selfTest,
  output logic            reserved
);

  // one-hot analog input select, one term per input
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_in
      assign analogSel[gi] = (code == 4'(gi)); // R10 R01
    end
  endgenerate

  // monitor, self-test and reserved codes
  assign supplySel    = (code == `SCSR_CODE_SUPPLY);   // R01
  assign regulatorSel = (code == `SCSR_CODE_REGMON);   // R01
  assign selfTest     = (code == `SCSR_CODE_SELFTEST); // R03
  assign reserved     = (code == `SCSR_CODE_RSV0) || (code >= `SCSR_CODE_RSV1);

endmodule
`default_nettype wire

// file: hdl/scsr_top.sv
// Purpose: sequencer stack, conversion readout and appended status word
// Assumes: resValid pulses once per started conversion
// Notes:   readout words are one-cycle pulses, no back-pressure
`timescale 1ns/1ps
`default_nettype none
`include "scsr_regs.svh"

module scsr_top (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [5:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  input  wire logic        convStart,
  output logic             convBusy,
  output logic      [4:0]  layerIdx,
  output logic      [7:0]  selAnalogA,
  output logic             selSupplyA,
  output logic             selRegMonA,
  output logic      [7:0]  selAnalogB,
  output logic             selSupplyB,
  output logic             selRegMonB,
  input  wire logic        resValid,
  input  wire logic [15:0] resA,
  input  wire logic [15:0] resB,
  output logic             outValid,
  output logic      [15:0] outData,
  output logic             outLast
);

  // checksum over the two result words, msb first
  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = `SCSR_CRC_INIT;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `SCSR_CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // layer value after a full or partial reset
  function automatic logic [8:0] layerInit(input int i);
    return (i < `SCSR_INIT_LAYERS) ? {1'b0, 4'(i), 4'(i)} : 9'h000;
  endfunction

  scsr_pkg::scsr_state_e stateReg, stateNext;
  logic [8:0]  stackReg [`SCSR_LAYERS];
  logic [8:0]  stackNext [`SCSR_LAYERS];
  logic [4:0]  ptrReg, ptrNext;
  logic [3:0]  codeAReg, codeANext;
  logic [3:0]  codeBReg, codeBNext;
  logic        finalReg, finalNext;
  logic [1:0]  cfgReg, cfgNext;
  logic [15:0] statusReg, statusNext;
  logic [15:0] wordBReg, wordBNext;
  logic [15:0] outDataReg, outDataNext;
  logic        outValidReg, outValidNext;
  logic        outLastReg, outLastNext;
  logic [15:0] rdataReg, rdataNext;
  logic        partReset;
  logic        appendEn;
  logic        selfTestA, selfTestB;
  logic [15:0] wordA, wordB;
  logic        takeRes;

  // select code decoders, one per converter with one mapping
  scsr_sel_decode u_decA (
    .code         (codeAReg),
    .analogSel    (selAnalogA),
    .supplySel    (selSupplyA),
    .regulatorSel (selRegMonA),
    .selfTest     (selfTestA),
    .reserved     ()
  ); // R02
  scsr_sel_decode u_decB (
    .code         (codeBReg),
    .analogSel    (selAnalogB),
    .supplySel    (selSupplyB),
    .regulatorSel (selRegMonB),
    .selfTest     (selfTestB),
    .reserved     ()
  ); // R01

  // result words, replaced by fixed patterns in self-test
  assign partReset = regWr && (regAddr == `SCSR_CFG_ADDR) && regWdata[`SCSR_CFG_PRESET];
  assign appendEn  = cfgReg[`SCSR_CFG_STATUS_EN] || cfgReg[`SCSR_CFG_CKSUM_EN]; // R05 R13
  assign wordA     = (selfTestA || selfTestB) ? `SCSR_TEST_A : resA; // R03
  assign wordB     = (selfTestA || selfTestB) ? `SCSR_TEST_B : resB; // R03
  assign takeRes   = (stateReg == scsr_pkg::S_CONV) && resValid;

  // register writes, stack layers and configuration
  always_comb begin
    cfgNext = cfgReg;
    for (int i = 0; i < `SCSR_LAYERS; i++) begin
      stackNext[i] = stackReg[i];
      if (partReset) begin
        stackNext[i] = layerInit(i); // R12
      end else if (regWr && regAddr == (`SCSR_STACK_BASE | 6'(i))) begin
        stackNext[i] = regWdata[8:0];
      end
    end
    if (regWr && regAddr == `SCSR_CFG_ADDR) begin
      cfgNext = regWdata[1:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `SCSR_LAYERS; i++) begin
        stackReg[i] <= layerInit(i); // R12
      end
      cfgReg <= 2'h0;
    end else begin
      stackReg <= stackNext;
      cfgReg   <= cfgNext;
    end
  end

  // register reads, data one cycle after the strobe
  always_comb begin
    rdataNext = 16'h0000;
    if (regRd) begin
      if (regAddr == `SCSR_CFG_ADDR) begin
        rdataNext = {14'h0000, cfgReg};
      end else if (regAddr == `SCSR_STAT_ADDR) begin
        rdataNext = statusReg; // R04
      end else if (regAddr >= `SCSR_STACK_BASE) begin
        rdataNext = {7'h00, stackReg[regAddr[4:0]]};
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdataReg <= 16'h0000;
    end else begin
      rdataReg <= rdataNext;
    end
  end

  // conversion sequencing and readout words
  always_comb begin
    stateNext    = stateReg;
    ptrNext      = ptrReg;
    codeANext    = codeAReg;
    codeBNext    = codeBReg;
    finalNext    = finalReg;
    statusNext   = statusReg; // R04
    wordBNext    = wordBReg;
    outDataNext  = outDataReg;
    outValidNext = 1'b0;
    outLastNext  = 1'b0;
    unique case (stateReg)
      scsr_pkg::S_IDLE: begin
        if (convStart) begin
          codeANext = stackReg[ptrReg][`SCSR_ASEL_MSB:`SCSR_ASEL_LSB];
          codeBNext = stackReg[ptrReg][`SCSR_BSEL_MSB:`SCSR_BSEL_LSB];
          finalNext = stackReg[ptrReg][`SCSR_FINAL_BIT];
          stateNext = scsr_pkg::S_CONV;
        end
      end
      scsr_pkg::S_CONV: begin
        if (resValid) begin
          statusNext   = {codeAReg, codeBReg, crc8({wordA, wordB})}; // R07 R08 R09
          wordBNext    = wordB;
          outDataNext  = wordA;
          outValidNext = 1'b1;
          ptrNext      = (finalReg || ptrReg == `SCSR_LAST_LAYER) ? 5'h00 : ptrReg + 5'h01; // R11
          stateNext    = scsr_pkg::S_WORDB;
        end
      end
      scsr_pkg::S_WORDB: begin
        outDataNext  = wordBReg;
        outValidNext = 1'b1;
        outLastNext  = !appendEn; // R13
        stateNext    = appendEn ? scsr_pkg::S_STATUS : scsr_pkg::S_IDLE; // R05 R06
      end
      scsr_pkg::S_STATUS: begin
        outDataNext  = statusReg; // R05
        outValidNext = 1'b1;
        outLastNext  = 1'b1;
        stateNext    = scsr_pkg::S_IDLE;
      end
    endcase
    if (partReset) begin
      stateNext = scsr_pkg::S_IDLE;
      ptrNext   = 5'h00; // R12
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stateReg    <= scsr_pkg::S_IDLE;
      ptrReg      <= 5'h00;
      codeAReg    <= 4'h0;
      codeBReg    <= 4'h0;
      finalReg    <= 1'b0;
      statusReg   <= 16'h0000;
      wordBReg    <= 16'h0000;
      outDataReg  <= 16'h0000;
      outValidReg <= 1'b0;
      outLastReg  <= 1'b0;
    end else begin
      stateReg    <= stateNext;
      ptrReg      <= ptrNext;
      codeAReg    <= codeANext;
      codeBReg    <= codeBNext;
      finalReg    <= finalNext;
      statusReg   <= statusNext;
      wordBReg    <= wordBNext;
      outDataReg  <= outDataNext;
      outValidReg <= outValidNext;
      outLastReg  <= outLastNext;
    end
  end

  // outputs
  assign regRdata = rdataReg;
  assign convBusy = (stateReg != scsr_pkg::S_IDLE);
  assign layerIdx = ptrReg;
  assign outValid = outValidReg;
  assign outData  = outDataReg;
  assign outLast  = outLastReg;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_code_map;
    (codeAReg <= 4'h4) |-> (selAnalogA == (8'h01 << codeAReg)) && !selSupplyA;
  endproperty
  a_code_map: assert property (p_code_map) else $error("low A code maps wrong input"); // R10

  property p_monitor_map;
    (codeBReg == 4'h8 |-> selSupplyB && selAnalogB == 8'h00) and
    (codeAReg == 4'h9 |-> selRegMonA && !selSupplyA) and
    (codeBReg == 4'h6 |-> selAnalogB == 8'h40);
  endproperty
  a_monitor_map: assert property (p_monitor_map) else $error("monitor code maps wrong input"); // R01 R02

  property p_selftest_words;
    takeRes && (codeAReg == 4'hB) && !partReset |=> outData == 16'hAAAA ##1 outData == 16'h5555;
  endproperty
  a_selftest_words: assert property (p_selftest_words) else $error("self-test patterns wrong"); // R03

  property p_status_ro;
    regWr && regAddr == `SCSR_STAT_ADDR && !takeRes |=> statusReg == $past(statusReg);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status word altered by write"); // R04

  property p_append;
    takeRes && appendEn && !partReset |=> outValid && !outLast ##1 outValid && !outLast
      ##1 outValid && outLast && outData == $past(statusReg, 2);
  endproperty
  a_append: assert property (p_append) else $error("status word not appended"); // R05 R06

  property p_no_append;
    takeRes && !appendEn && !partReset |=> ##1 outValid && outLast ##1 !outValid;
  endproperty
  a_no_append: assert property (p_no_append) else $error("status appended while disabled"); // R13

  property p_indices;
    takeRes |=> statusReg[15:12] == $past(codeAReg) && statusReg[11:8] == $past(codeBReg);
  endproperty
  a_indices: assert property (p_indices) else $error("status channel index wrong"); // R07 R08

  property p_checksum;
    takeRes |=> statusReg[7:0] == crc8({$past(wordA), $past(wordB)});
  endproperty
  a_checksum: assert property (p_checksum) else $error("status checksum wrong"); // R09

  property p_advance;
    takeRes && !partReset |=> ptrReg == (($past(finalReg) || $past(ptrReg) == 5'h1F) ? 5'h00
      : $past(ptrReg) + 5'h01);
  endproperty
  a_advance: assert property (p_advance) else $error("layer pointer stepped wrong"); // R11

  property p_preset;
    partReset |=> ptrReg == 5'h00 && stackReg[3] == 9'h033 && stackReg[8] == 9'h000;
  endproperty
  a_preset: assert property (p_preset) else $error("partial reset did not reload stack"); // R12

  c_append:   cover property (takeRes && appendEn ##3 outLast);
  c_selftest: cover property (takeRes && selfTestA);
  c_wrap:     cover property (takeRes && finalReg);

endmodule
`default_nettype wire

// file: verif/scsr_host_model.sv
// Purpose: host side model, starts conversions and collects readout words
// Assumes: one conversion in flight at a time
// Notes:   result lines show inverted data outside the valid pulse
`timescale 1ns/1ps
`default_nettype none

module scsr_host_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic [15:0] aVal,
  input  wire logic [15:0] bVal,
  input  wire logic        outValid,
  input  wire logic [15:0] outData,
  input  wire logic        outLast,
  output logic             convStart,
  output logic             resValid,
  output logic      [15:0] resA,
  output logic      [15:0] resB,
  output logic      [15:0] words [0:3],
  output logic      [1:0]  lastCnt
);
  logic [1:0] idx;

  // start pulse, settle gap, then one result pulse
  initial begin
    convStart = 1'b0;
    resValid = 1'b0;
    resA = 16'h0000;
    resB = 16'hFFFF;
    forever begin
      @(posedge mclk);
      if (go) begin
        convStart <= 1'b1;
        @(posedge mclk);
        convStart <= 1'b0;
        repeat (3) @(posedge mclk);
        resValid <= 1'b1;
        resA <= aVal;
        resB <= bVal;
        @(posedge mclk);
        resValid <= 1'b0;
        resA <= ~aVal;
        resB <= ~bVal;
      end
    end
  end

  // collect the words of each readout
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      idx <= 2'h0;
      lastCnt <= 2'h0;
    end else if (outValid) begin
      words[idx] <= outData;
      idx <= outLast ? 2'h0 : idx + 2'h1;
      if (outLast) lastCnt <= idx + 2'h1;
    end
  end
endmodule
`default_nettype wire

// file: verif/scsr_top_tb.sv
// Purpose: self-checking bench of the sequencer readout block
// Assumes: host model drives conversion start and results
// Notes:   expected decode and checksum worked out here
`timescale 1ns/1ps
`default_nettype none
`include "scsr_regs.svh"

module scsr_top_tb;
  logic        mclk, rst, regWr, regRd, convStart, convBusy, resValid, outValid, outLast, go;
  logic        selSupplyA, selRegMonA, selSupplyB, selRegMonB;
  logic [5:0]  regAddr;
  logic [4:0]  layerIdx, lay;
  logic [7:0]  selAnalogA, selAnalogB;
  logic [15:0] regWdata, regRdata, resA, resB, outData, aVal, bVal, stat;
  logic [15:0] words [0:3];
  logic [1:0]  lastCnt;
  int          failures, checkCount, cycles;

  scsr_top scsr_top_i (.mclk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .convStart, .convBusy,
    .layerIdx, .selAnalogA, .selSupplyA, .selRegMonA, .selAnalogB, .selSupplyB, .selRegMonB, .resValid,
    .resA, .resB, .outValid, .outData, .outLast);
  scsr_host_model scsr_host_model_i (.mclk, .rst, .go, .aVal, .bVal, .outValid, .outData, .outLast,
    .convStart, .resValid, .resA, .resB, .words, .lastCnt);

  // clock, 8 ns period
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // cycle ceiling against hangs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      wrap_up();
    end
  end

  // expected {one-hot input, supply, regulator} of a select code
  function automatic logic [9:0] dec(input logic [3:0] c);
    dec = 10'h000;
    if (c < 4'h8) dec[c + 2] = 1'b1;
    else if (c == `SCSR_CODE_SUPPLY) dec[1] = 1'b1;
    else if (c == `SCSR_CODE_REGMON) dec[0] = 1'b1;
  endfunction

  // checksum of both result words, msb first
  function automatic logic [7:0] crc(input logic [31:0] d);
    crc = `SCSR_CRC_INIT;
    for (int i = 31; i >= 0; i--) crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ d[i]) ? `SCSR_CRC_POLY : 8'h00);
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checkCount = checkCount + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk("regRdata", e, regRdata);
  endtask

  task automatic waitBusy(input logic lvl);
    int n;
    n = 0;
    while (convBusy !== lvl && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("convBusy", {15'h0000, lvl}, {15'h0000, convBusy});
  endtask

  // program the current layer, convert it and check the readout
  task automatic seq(input logic [3:0] a, input logic [3:0] b, input logic fin, input logic app);
    logic        st;
    logic [15:0] ea, eb;
    st = (a == `SCSR_CODE_SELFTEST) || (b == `SCSR_CODE_SELFTEST);
    ea = {a, b, a, b} ^ 16'h1E3C;
    eb = ~ea;
    wr(`SCSR_STACK_BASE + {1'b0, lay}, {7'h00, fin, b, a});
    aVal <= ea;
    bVal <= eb;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    if (st) begin
      ea = `SCSR_TEST_A;
      eb = `SCSR_TEST_B;
    end
    stat = {a, b, crc({ea, eb})};
    lay = fin ? 5'h00 : lay + 5'h01;
    waitBusy(1'b1);
    if (!st) begin
      chk("selA", {6'h00, dec(a)}, {6'h00, selAnalogA, selSupplyA, selRegMonA});
      chk("selB", {6'h00, dec(b)}, {6'h00, selAnalogB, selSupplyB, selRegMonB});
    end
    waitBusy(1'b0);
    // busy falls as the last word is launched, the host takes it one edge later
    @(posedge mclk);
    #1;
    chk("outWordA", ea, words[0]);
    chk("outWordB", eb, words[1]);
    chk("wordCount", {14'h0000, 1'b1, app}, {14'h0000, lastCnt});
    if (app) chk("statusWord", stat, words[2]);
    chk("layerIdx", {11'h000, lay}, {11'h000, layerIdx});
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    regAddr = 6'h00;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    go = 1'b0;
    aVal = 16'h0000;
    bVal = 16'h0000;
    lay = 5'h00;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    // stack, config and an unmapped place after reset
    for (int i = 0; i < `SCSR_LAYERS; i++) rd(`SCSR_STACK_BASE + i[5:0], i < 8 ? {8'h00, i[3:0], i[3:0]} : 16'h0000);
    rd(`SCSR_CFG_ADDR, 16'h0000);
    rd(6'h00, 16'h0000);
    // every documented input code, reserved codes never written
    for (int c = 0; c < 10; c++) seq(c[3:0], 4'h9 - c[3:0], c[0], 1'b0);
    // appended status word with either enable
    wr(`SCSR_CFG_ADDR, 16'h0001);
    seq(4'h5, 4'h8, 1'b0, 1'b1);
    rd(`SCSR_STAT_ADDR, stat);
    wr(`SCSR_STAT_ADDR, ~stat);
    rd(`SCSR_STAT_ADDR, stat);
    wr(`SCSR_CFG_ADDR, 16'h0002);
    seq(4'hB, 4'h3, 1'b0, 1'b1);
    seq(4'h7, 4'hB, 1'b1, 1'b1);
    wr(`SCSR_CFG_ADDR, 16'h0000);
    seq(4'h2, 4'h6, 1'b0, 1'b0);
    // partial reset reloads the stack and the pointer
    wr(`SCSR_CFG_ADDR, 16'h0004);
    lay = 5'h00;
    rd(`SCSR_STACK_BASE, 16'h0000);
    rd(`SCSR_STACK_BASE + 6'h02, 16'h0022);
    chk("layerIdx", 16'h0000, {11'h000, layerIdx});
    wrap_up();
  end
endmodule
`default_nettype wire
